// file: rtl/wdt_rst_unit.sv
// watchdog timer with normal and window modes, plus reset-cause flags and soft reset
// assumes cpu protection logic on the same clock, reset sources arriving asynchronously
//
// What this block does
// [RL1] watchdog reset pulse: one to two 2MHz periods
// [RL2] soft reset issued within two cycles of write
// [RL3] cpu stalled between soft request and reset
// [RL4] debug reset only from external debug port
// [RL5] cause flags: soft5 debug4 wdog3 brown2 pin1 por0
// [RL6] non-por flags clear on por or write-one
// [RL7] por flag set by por, cleared by write-one
// [RL8] soft request bit0 at 0x01, self-clearing
// [RL9] soft request write needs protection unlock
// [RL10] software writes zero to reserved bits, reads zero
// [RL11] enabled watchdog resets when not serviced in time
// [RL12] normal mode service restarts full period anytime
// [RL13] eleven periods 8ms to 8s, both fields
// [RL14] window service while closed resets immediately
// [RL15] open follows closed; open service restarts closed
// [RL16] default period codes come from fuses
// [RL17] watchdog counts on 1kHz low-power tick
// [RL18] watchdog counts regardless of sleep or cpu clock
// [RL19] control write needs unlock plus change-enable
// [RL20] lock fuse freezes control, reloads after reset
// [RL21] lock freezes closed code, window enable writable
// [RL22] control: code 5:2, enable 1, change-enable 0
// [RL23] code n gives 8<<n ticks; 11..15 never expire
// [RL24] window control: code 5:2, enable 1, change 0
// [RL25] busy flag while write syncs, only when enabled
// [RL26] service request passed to tick domain, acknowledged
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
module wdt_rst_unit #(
	parameter int TICK_DIV = wdt_rst_pkg::TICK_CYCLES
) (
	input  wire logic       CORE_CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic [7:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output logic      [7:0] RDATA_O,
	input  wire logic       PROT_OPEN_I,
	input  wire logic       SERVICE_I,
	input  wire logic [3:0] FUSE_PER_I,
	input  wire logic [3:0] FUSE_WPER_I,
	input  wire logic       FUSE_EN_I,
	input  wire logic       FUSE_LOCK_I,
	input  wire logic       BROWNOUT_RST_I,
	input  wire logic       PIN_RST_I,
	input  wire logic       DEBUG_PORT_RST_I,
	output logic            SYS_RST_O,
	output logic            CPU_STALL_O
);

	// ==========================================================
	// functions
	function automatic logic [13:0] period_ticks(input logic [3:0] code);
		if (code > wdt_rst_pkg::CODE_LAST)
			return 14'h0000;                                    // [RL23]
		return 14'(14'h0008 << code);                           // [RL13] [RL23]
	endfunction

	function automatic logic [3:0] code_of(input logic [7:0] v);
		return v[wdt_rst_pkg::CODE_MSB:wdt_rst_pkg::CODE_LSB];
	endfunction

	// ==========================================================
	// input synchronisers
	logic [2:0] src_meta_q;
	logic [2:0] src_sync_q;

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			src_meta_q <= 3'h0;
			src_sync_q <= 3'h0;
		end else begin
			src_meta_q <= {DEBUG_PORT_RST_I, PIN_RST_I, BROWNOUT_RST_I};
			src_sync_q <= src_meta_q;
		end
	end

	// ==========================================================
	// low-power tick: one-cycle enable, never gated by sleep or cpu state
	logic [17:0] div_q;
	logic [17:0] div_d;
	logic        tick;

	assign tick = (div_q == 18'(TICK_DIV - 1));

	always_comb begin
		div_d = tick ? 18'h00000 : div_q + 18'h00001;         // [RL17] [RL18]
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I)
			div_q <= 18'h00000;
		else
			div_q <= div_d;
	end

	// ==========================================================
	// state
	logic        fuse_loaded_q, fuse_loaded_d;
	logic [3:0]  per_q, per_d;
	logic        en_q, en_d;
	logic [3:0]  wper_q, wper_d;
	logic        wen_q, wen_d;
	logic        lock_q, lock_d;
	logic [3:0]  act_per_q, act_per_d;
	logic        act_en_q, act_en_d;
	logic [3:0]  act_wper_q, act_wper_d;
	logic        act_wen_q, act_wen_d;
	logic        busy_q, busy_d;
	logic        svc_pend_q, svc_pend_d;
	logic [13:0] cnt_q, cnt_d;
	wdt_rst_pkg::phase_t phase_q, phase_d;
	logic [5:0]  cause_q, cause_d;
	logic        swreq_q, swreq_d;
	logic [7:0]  pulse_q, pulse_d;
	logic        wd_fire, soft_fire;

	logic wr_cause, wr_rctl, wr_wctl, wr_win;
	assign wr_cause = WR_I && (ADDR_I == wdt_rst_pkg::ADDR_CAUSE);
	assign wr_rctl  = WR_I && (ADDR_I == wdt_rst_pkg::ADDR_RST_CTRL);
	assign wr_wctl  = WR_I && (ADDR_I == wdt_rst_pkg::ADDR_WDT_CTRL);
	assign wr_win   = WR_I && (ADDR_I == wdt_rst_pkg::ADDR_WDT_WIN);

	logic ctl_ok, win_ok;
	assign ctl_ok = wr_wctl && PROT_OPEN_I && WDATA_I[wdt_rst_pkg::BIT_CHG]
		&& !lock_q;                                             // [RL19] [RL20]
	assign win_ok = wr_win && PROT_OPEN_I && WDATA_I[wdt_rst_pkg::BIT_CHG]; // [RL19]

	logic [13:0] closed_lim, open_lim;
	logic        closed_svc;
	assign closed_lim = period_ticks(act_wper_q);
	assign open_lim   = period_ticks(act_per_q);
	// an early service is punished at once, not at the next tick
	assign closed_svc = SERVICE_I && act_en_q && (phase_q == wdt_rst_pkg::PH_CLOSED); // [RL14]

	logic sys_rst_now;
	assign sys_rst_now = (pulse_q != 8'h00) || (|src_sync_q);

	always_comb begin
		fuse_loaded_d = 1'b1;
		per_d      = per_q;
		en_d       = en_q;
		wper_d     = wper_q;
		wen_d      = wen_q;
		lock_d     = lock_q;
		act_per_d  = act_per_q;
		act_en_d   = act_en_q;
		act_wper_d = act_wper_q;
		act_wen_d  = act_wen_q;
		busy_d     = busy_q;
		svc_pend_d = svc_pend_q;
		cnt_d      = cnt_q;
		phase_d    = phase_q;
		wd_fire    = 1'b0;

		if (!fuse_loaded_q || sys_rst_now) begin
			// fuse defaults re-applied on every system reset
			per_d      = FUSE_PER_I;                            // [RL16] [RL20]
			wper_d     = FUSE_WPER_I;                           // [RL16]
			en_d       = FUSE_EN_I;
			wen_d      = 1'b0;
			lock_d     = FUSE_LOCK_I;
			act_per_d  = FUSE_PER_I;
			act_wper_d = FUSE_WPER_I;
			act_en_d   = FUSE_EN_I;
			act_wen_d  = 1'b0;
			busy_d     = 1'b0;
			svc_pend_d = 1'b0;
			cnt_d      = 14'h0000;
			phase_d    = wdt_rst_pkg::PH_IDLE;
		end else begin
			if (ctl_ok) begin
				per_d = code_of(WDATA_I);                       // [RL22]
				en_d  = WDATA_I[wdt_rst_pkg::BIT_EN];
			end
			if (win_ok) begin
				if (!lock_q)
					wper_d = code_of(WDATA_I);                  // [RL21] [RL24]
				wen_d = WDATA_I[wdt_rst_pkg::BIT_EN];           // [RL21]
			end
			// hand-off to the tick domain only happens while running
			if ((ctl_ok || win_ok) && act_en_q)
				busy_d = 1'b1;                                  // [RL25]
			if (SERVICE_I && act_en_q && !closed_svc)
				svc_pend_d = 1'b1;                              // [RL26]
			if (closed_svc)
				wd_fire = 1'b1;                                 // [RL14]

			if (!act_en_q) begin
				act_per_d  = per_d;
				act_en_d   = en_d;
				act_wper_d = wper_d;
				act_wen_d  = wen_d;
				cnt_d      = 14'h0000;
				phase_d    = wdt_rst_pkg::PH_IDLE;
				svc_pend_d = 1'b0;
			end else if (tick) begin
				act_per_d  = per_q;
				act_en_d   = en_q;
				act_wper_d = wper_q;
				act_wen_d  = wen_q;
				busy_d     = ctl_ok || win_ok;                  // [RL25]
				svc_pend_d = SERVICE_I && !closed_svc;          // [RL26]
				if (svc_pend_q) begin
					cnt_d   = 14'h0000;                         // [RL12]
					phase_d = act_wen_q ? wdt_rst_pkg::PH_CLOSED
						: wdt_rst_pkg::PH_OPEN;                 // [RL15]
				end else begin
					cnt_d = cnt_q + 14'h0001;                   // [RL11]
					case (phase_q)
						wdt_rst_pkg::PH_IDLE: begin
							cnt_d   = 14'h0000;
							phase_d = act_wen_q ? wdt_rst_pkg::PH_CLOSED
								: wdt_rst_pkg::PH_OPEN;
						end
						wdt_rst_pkg::PH_CLOSED: begin
							if (cnt_d >= closed_lim) begin
								cnt_d   = 14'h0000;
								phase_d = wdt_rst_pkg::PH_OPEN; // [RL15]
							end
						end
						wdt_rst_pkg::PH_OPEN: begin
							if (open_lim != 14'h0000 && cnt_d >= open_lim)
								wd_fire = 1'b1;                 // [RL11]
						end
						default: begin
							phase_d = wdt_rst_pkg::PH_IDLE;
						end
					endcase
				end
			end
		end
	end

	// ==========================================================
	// reset control and cause flags
	assign soft_fire = swreq_q;

	always_comb begin
		swreq_d = swreq_q;
		pulse_d = pulse_q;
		cause_d = cause_q;
		if (soft_fire)
			swreq_d = 1'b0;                                     // [RL8]
		else if (wr_rctl && PROT_OPEN_I && WDATA_I[wdt_rst_pkg::BIT_SWREQ])
			swreq_d = 1'b1;                                     // [RL8] [RL9]
		if (wd_fire || soft_fire)
			pulse_d = 8'(wdt_rst_pkg::RST_PULSE_CYCLES);        // [RL1] [RL2]
		else if (pulse_q != 8'h00)
			pulse_d = pulse_q - 8'h01;
		if (wr_cause)
			cause_d = cause_q & ~WDATA_I[5:0];                  // [RL6] [RL7]
		// a set in the clearing cycle wins
		if (soft_fire)
			cause_d[wdt_rst_pkg::BIT_SOFT] = 1'b1;              // [RL5]
		if (wd_fire)
			cause_d[wdt_rst_pkg::BIT_WDOG] = 1'b1;              // [RL5]
		if (src_sync_q[2])
			cause_d[wdt_rst_pkg::BIT_DEBUG] = 1'b1;             // [RL4] [RL5]
		if (src_sync_q[1])
			cause_d[wdt_rst_pkg::BIT_PIN] = 1'b1;
		if (src_sync_q[0])
			cause_d[wdt_rst_pkg::BIT_BROWN] = 1'b1;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			fuse_loaded_q <= 1'b0;
			per_q      <= 4'h0;
			en_q       <= 1'b0;
			wper_q     <= 4'h0;
			wen_q      <= 1'b0;
			lock_q     <= 1'b0;
			act_per_q  <= 4'h0;
			act_en_q   <= 1'b0;
			act_wper_q <= 4'h0;
			act_wen_q  <= 1'b0;
			busy_q     <= wdt_rst_pkg::BUSY_RESET;
			svc_pend_q <= 1'b0;
			cnt_q      <= 14'h0000;
			phase_q    <= wdt_rst_pkg::PH_IDLE;
			cause_q    <= wdt_rst_pkg::CAUSE_RESET;             // [RL7]
			swreq_q    <= wdt_rst_pkg::SWREQ_RESET;
			pulse_q    <= 8'h00;
		end else begin
			fuse_loaded_q <= fuse_loaded_d;
			per_q      <= per_d;
			en_q       <= en_d;
			wper_q     <= wper_d;
			wen_q      <= wen_d;
			lock_q     <= lock_d;
			act_per_q  <= act_per_d;
			act_en_q   <= act_en_d;
			act_wper_q <= act_wper_d;
			act_wen_q  <= act_wen_d;
			busy_q     <= busy_d;
			svc_pend_q <= svc_pend_d;
			cnt_q      <= cnt_d;
			phase_q    <= phase_d;
			cause_q    <= cause_d;
			swreq_q    <= swreq_d;
			pulse_q    <= pulse_d;
		end
	end

	// soft request is seen the cycle after its write, so the pulse starts one cycle later
	assign SYS_RST_O   = sys_rst_now || soft_fire;                                // [RL2]
	assign CPU_STALL_O = swreq_q || (wr_rctl && PROT_OPEN_I
		&& WDATA_I[wdt_rst_pkg::BIT_SWREQ]);                                       // [RL3]

	// ==========================================================
	// read port, unmapped and reserved bits read zero
	logic [7:0] rdata_d;

	always_comb begin
		rdata_d = RDATA_O;
		if (RD_I) begin
			case (ADDR_I)
				wdt_rst_pkg::ADDR_CAUSE:    rdata_d = {2'b00, cause_q};          // [RL10]
				wdt_rst_pkg::ADDR_RST_CTRL: rdata_d = {7'h00, swreq_q};
				wdt_rst_pkg::ADDR_WDT_CTRL: rdata_d = {2'b00, per_q, en_q, 1'b0};
				wdt_rst_pkg::ADDR_WDT_WIN:  rdata_d = {2'b00, wper_q, wen_q, 1'b0};
				wdt_rst_pkg::ADDR_WDT_STAT: rdata_d = {7'h00, busy_q};
				default:                    rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I)
			RDATA_O <= 8'h00;
		else
			RDATA_O <= rdata_d;
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);

	int pulse_len_q;
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I)
			pulse_len_q <= 0;
		else if (wd_fire || soft_fire)
			pulse_len_q <= 0;
		else if (pulse_q != 8'h00)
			pulse_len_q <= pulse_len_q + 1;
	end

	a_pulse_length: assert property (                                        // [RL1]
		$fell(pulse_q != 8'h00) |-> pulse_len_q == wdt_rst_pkg::RST_PULSE_CYCLES)
		else $error("watchdog reset pulse length wrong");
	a_soft_latency: assert property (                                        // [RL2]
		(wr_rctl && PROT_OPEN_I && WDATA_I[0] && !swreq_q) |-> ##[1:2] SYS_RST_O)
		else $error("soft reset late");
	a_stall_held: assert property (                                          // [RL3]
		swreq_q |-> CPU_STALL_O && SYS_RST_O)
		else $error("cpu not stalled during soft reset");
	a_soft_needs_unlock: assert property (                                   // [RL9]
		$rose(swreq_q) |-> $past(PROT_OPEN_I))
		else $error("soft reset taken without unlock");
	a_soft_selfclear: assert property (                                      // [RL8]
		swreq_q |=> !swreq_q ##0 cause_q[wdt_rst_pkg::BIT_SOFT])
		else $error("soft request did not clear");
	a_locked_period: assert property (                                       // [RL20]
		(lock_q && !sys_rst_now && fuse_loaded_q) |=> $stable(per_q) && $stable(en_q))
		else $error("locked control changed");
	a_locked_window: assert property (                                       // [RL21]
		(lock_q && !sys_rst_now && fuse_loaded_q) |=> $stable(wper_q))
		else $error("locked closed code changed");
	a_ctrl_needs_chg: assert property (                                      // [RL19]
		(fuse_loaded_q && !sys_rst_now && !ctl_ok) |=> $stable(per_q))
		else $error("control changed without change enable");
	a_early_service: assert property (                                       // [RL14]
		closed_svc && !sys_rst_now |=> pulse_q == 8'(wdt_rst_pkg::RST_PULSE_CYCLES)
			&& cause_q[wdt_rst_pkg::BIT_WDOG])
		else $error("closed window service did not reset");
	a_busy_disabled: assert property (                                       // [RL25]
		!act_en_q |=> !busy_q)
		else $error("busy set while watchdog disabled");
	a_flag_set_wins: assert property (                                       // [RL6]
		wd_fire |=> cause_q[wdt_rst_pkg::BIT_WDOG])
		else $error("watchdog flag lost");

	c_wdog_timeout: cover property (tick && phase_q == wdt_rst_pkg::PH_OPEN && wd_fire);
	c_early_service: cover property (closed_svc);
	c_soft_reset: cover property (soft_fire);
	c_window_open: cover property (phase_q == wdt_rst_pkg::PH_CLOSED
		##[1:1000] phase_q == wdt_rst_pkg::PH_OPEN);

endmodule

// file: rtl/wdt_rst_pkg.sv
// constants shared by the watchdog and reset-cause unit
// assumes a 200 MHz core clock and a 1 kHz low-power tick derived from it
package wdt_rst_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_CAUSE    = 8'h00;
	localparam logic [7:0] ADDR_RST_CTRL = 8'h01;
	localparam logic [7:0] ADDR_WDT_CTRL = 8'h10;
	localparam logic [7:0] ADDR_WDT_WIN  = 8'h11;
	localparam logic [7:0] ADDR_WDT_STAT = 8'h12;

	// ==========================================================
	// field positions
	localparam int BIT_SOFT    = 5;
	localparam int BIT_DEBUG   = 4;
	localparam int BIT_WDOG    = 3;
	localparam int BIT_BROWN   = 2;
	localparam int BIT_PIN     = 1;
	localparam int BIT_POR     = 0;
	localparam int BIT_SWREQ   = 0;
	localparam int BIT_CHG     = 0;
	localparam int BIT_EN      = 1;
	localparam int CODE_LSB    = 2;
	localparam int CODE_MSB    = 5;
	localparam int BIT_BUSY    = 0;

	// ==========================================================
	// reset values and last valid period code
	localparam logic [5:0] CAUSE_RESET    = 6'h01;
	localparam logic       SWREQ_RESET    = 1'b0;
	localparam logic       BUSY_RESET     = 1'b0;
	localparam logic [3:0] CODE_LAST      = 4'hA;

	// ==========================================================
	// timing
	localparam int CORE_CLK_MHZ      = 200;
	localparam int TICK_HZ           = 1000;
	localparam int TICK_CYCLES       = CORE_CLK_MHZ * 1000000 / TICK_HZ;
	localparam int OSC2M_PERIOD_NS   = 500;
	localparam int RST_PULSE_CYCLES  = (OSC2M_PERIOD_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int RST_PULSE_MAX     = 2 * OSC2M_PERIOD_NS * CORE_CLK_MHZ / 1000;
	localparam int SOFT_RST_LATENCY  = 2;

	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00,
		PH_CLOSED = 2'b01,
		PH_OPEN   = 2'b10
	} phase_t;

endpackage

// file: dv/tb_wdt_rst_unit.sv
// directed testbench for the watchdog and reset-cause unit
// assumes the unit's register map from its package; the tick divider parameter is set here to TD
`timescale 1ns/10ps
module tb_wdt_rst_unit;
	// ==========================================================
	// setup
	// short tick keeps every watchdog period the tests run within a few thousand cycles
	localparam int         TD   = 20;
	localparam logic [7:0] A_C  = wdt_rst_pkg::ADDR_CAUSE;
	localparam logic [7:0] A_RC = wdt_rst_pkg::ADDR_RST_CTRL;
	localparam logic [7:0] A_WC = wdt_rst_pkg::ADDR_WDT_CTRL;
	localparam logic [7:0] A_WW = wdt_rst_pkg::ADDR_WDT_WIN;
	localparam logic [7:0] A_ST = wdt_rst_pkg::ADDR_WDT_STAT;
	logic       clk, rst_n, we, re, prot, svc, f_en, f_lock, brown, pin, dbg, sys_rst, stall;
	logic [7:0] addr, wdata, rdata;
	logic [3:0] f_per, f_wper;
	int         failures, total_checks;

	wdt_rst_unit #(.TICK_DIV(TD)) dut_u (
		.CORE_CLK_I      (clk),
		.RST_N_I         (rst_n),
		.ADDR_I          (addr),
		.WDATA_I         (wdata),
		.WR_I            (we),
		.RD_I            (re),
		.RDATA_O         (rdata),
		.PROT_OPEN_I     (prot),
		.SERVICE_I       (svc),
		.FUSE_PER_I      (f_per),
		.FUSE_WPER_I     (f_wper),
		.FUSE_EN_I       (f_en),
		.FUSE_LOCK_I     (f_lock),
		.BROWNOUT_RST_I  (brown),
		.PIN_RST_I       (pin),
		.DEBUG_PORT_RST_I(dbg),
		.SYS_RST_O       (sys_rst),
		.CPU_STALL_O     (stall)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic p);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		prot <= p;
		@(posedge clk);
		we <= 1'b0;
		prot <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1;
		chk(nm, rdata, exp);
	endtask

	task automatic service();
		@(posedge clk);
		svc <= 1'b1;
		@(posedge clk);
		svc <= 1'b0;
	endtask

	task automatic wait_rst(input int hi, output int n);
		n = 0;
		while (sys_rst !== 1'b1 && n < hi) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	// also lets the unit settle a few cycles once reset is gone
	task automatic pulse_len(output int w);
		w = 0;
		while (sys_rst === 1'b1 && w < 400) begin
			@(posedge clk);
			#1;
			w++;
		end
		repeat (3) @(posedge clk);
	endtask

	// flags whether a reset shows up in any cycle while nothing should fire
	task automatic quiet(input int cyc, inout logic seen);
		repeat (cyc) begin
			@(posedge clk);
			#1;
			seen = seen | sys_rst;
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset_values();
		rd_chk(A_C, 8'h01, "cause_reset");
		rd_chk(A_RC, 8'h00, "rst_ctrl_reset");
		rd_chk(A_WC, 8'h0C, "wdt_ctrl_fuse");
		rd_chk(A_WW, 8'h08, "wdt_win_fuse");
		rd_chk(A_ST, 8'h00, "status_reset");
		rd_chk(8'h20, 8'h00, "unmapped");
		$display("done reset_values");
	endtask

	task automatic t_w1c();
		bus_wr(A_C, 8'h00, 1'b0);
		rd_chk(A_C, 8'h01, "cause_write_zero");
		bus_wr(A_C, 8'h01, 1'b0);
		rd_chk(A_C, 8'h00, "cause_w1c_por");
		$display("done w1c");
	endtask

	task automatic t_soft();
		int n;
		bus_wr(A_RC, 8'h01, 1'b0);
		repeat (3) @(posedge clk);
		#1 chk("soft_locked_out", {7'h0, sys_rst}, 8'h00);
		@(posedge clk);
		we <= 1'b1;
		addr <= A_RC;
		wdata <= 8'h01;
		prot <= 1'b1;
		#1 chk("stall_write", {7'h0, stall}, 8'h01);
		@(posedge clk);
		we <= 1'b0;
		prot <= 1'b0;
		#1 chk("soft_rst", {7'h0, sys_rst}, 8'h01);
		chk("stall_pending", {7'h0, stall}, 8'h01);
		pulse_len(n);
		rd_chk(A_RC, 8'h00, "soft_self_clear");
		rd_chk(A_C, 8'h20, "soft_flag");
		$display("done soft");
	endtask

	task automatic t_guard();
		bus_wr(A_WC, 8'h02, 1'b1);
		rd_chk(A_WC, 8'h0C, "no_change_enable");
		bus_wr(A_WC, 8'h03, 1'b0);
		rd_chk(A_WC, 8'h0C, "no_unlock");
		$display("done guard");
	endtask

	task automatic t_expire();
		int n;
		int w;
		bus_wr(A_WC, 8'h03, 1'b1);
		rd_chk(A_WC, 8'h02, "ctrl_readback");
		wait_rst(11 * TD, n);
		chk("expire_time", {7'h0, n >= 7 * TD && n <= 10 * TD + 5}, 8'h01);
		pulse_len(w);
		chk("pulse_width", w[7:0], 8'(wdt_rst_pkg::RST_PULSE_CYCLES));
		rd_chk(A_C, 8'h28, "wdog_flag");
		rd_chk(A_WC, 8'h0C, "reload_fuse");
		$display("done expire");
	endtask

	task automatic t_keep();
		logic seen;
		int n;
		seen = 1'b0;
		bus_wr(A_WC, 8'h03, 1'b1);
		repeat (20) begin
			service();
			quiet(60, seen);
		end
		chk("kept_alive", {7'h0, seen}, 8'h00);
		wait_rst(11 * TD, n);
		chk("unserviced", {7'h0, sys_rst}, 8'h01);
		pulse_len(n);
		$display("done keep");
	endtask

	task automatic t_win_closed();
		int n;
		bus_wr(A_WW, 8'h07, 1'b1);
		bus_wr(A_WC, 8'h03, 1'b1);
		repeat (3 * TD) @(posedge clk);
		service();
		wait_rst(2 * TD, n);
		chk("closed_service", {7'h0, sys_rst}, 8'h01);
		pulse_len(n);
		rd_chk(A_WW, 8'h08, "win_reload");
		$display("done win_closed");
	endtask

	task automatic t_win_open();
		logic seen;
		int n;
		seen = 1'b0;
		bus_wr(A_WW, 8'h03, 1'b1);
		bus_wr(A_WC, 8'h07, 1'b1);
		repeat (3) begin
			quiet(13 * TD, seen);
			service();
		end
		chk("open_service", {7'h0, seen}, 8'h00);
		wait_rst(28 * TD, n);
		chk("closed_plus_open", {7'h0, n >= 22 * TD && n < 28 * TD}, 8'h01);
		pulse_len(n);
		$display("done win_open");
	endtask

	task automatic t_reserved();
		logic seen;
		seen = 1'b0;
		bus_wr(A_WC, 8'h2F, 1'b1);
		rd_chk(A_WC, 8'h2E, "code_eleven");
		quiet(200 * TD, seen);
		chk("reserved_silent", {7'h0, seen}, 8'h00);
		bus_wr(A_WC, 8'h2D, 1'b1);
		rd_chk(A_WC, 8'h2C, "disabled");
		$display("done reserved");
	endtask

	task automatic t_sources();
		logic [7:0] exp;
		int n;
		exp = 8'h00;
		bus_wr(A_C, 8'h3F, 1'b0);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			brown <= (i == 0);
			pin <= (i == 1);
			dbg <= (i == 2);
			repeat (6) @(posedge clk);
			#1 chk("source_rst", {7'h0, sys_rst}, 8'h01);
			@(posedge clk);
			brown <= 1'b0;
			pin <= 1'b0;
			dbg <= 1'b0;
			pulse_len(n);
			exp = exp | ((i == 0) ? 8'h04 : (i == 1) ? 8'h02 : 8'h10);
			rd_chk(A_C, exp, "source_flag");
		end
		$display("done sources");
	endtask

	task automatic t_lock();
		int n;
		@(posedge clk);
		f_lock <= 1'b1;
		bus_wr(A_RC, 8'h01, 1'b1);
		wait_rst(10, n);
		pulse_len(n);
		bus_wr(A_WC, 8'h03, 1'b1);
		rd_chk(A_WC, 8'h0C, "locked_ctrl");
		bus_wr(A_WW, 8'h17, 1'b1);
		rd_chk(A_WW, 8'h0A, "locked_window");
		$display("done lock");
	endtask

	// power-on reset in mid-run; first tick lands TD cycles after release
	task automatic t_por();
		@(posedge clk);
		rst_n <= 1'b0;
		f_lock <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		bus_wr(A_WC, 8'h03, 1'b1);
		bus_wr(A_WW, 8'h01, 1'b1);
		rd_chk(A_ST, 8'h01, "busy_set");
		rd_chk(A_C, 8'h01, "cause_after_por");
		repeat (TD) @(posedge clk);
		rd_chk(A_ST, 8'h00, "busy_cleared");
		$display("done por");
	endtask

	// ==========================================================
	// run
	initial begin
		failures = 0;
		total_checks = 0;
		{rst_n, we, re, prot, svc, f_en, f_lock, brown, pin, dbg} = '0;
		addr = 8'h00;
		wdata = 8'h00;
		f_per = 4'h3;
		f_wper = 4'h2;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset_values();
		t_w1c();
		t_soft();
		t_guard();
		t_expire();
		t_keep();
		t_win_closed();
		t_win_open();
		t_reserved();
		t_sources();
		t_lock();
		t_por();
		give_verdict();
	end

	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule
